// ### rtl/pao_defs.vh
`ifndef PAO_DEFS_VH
`define PAO_DEFS_VH

// ==========================================================================
// register map, byte addresses on the avalon slave
// ==========================================================================
`define PAO_ADDR_W          8
`define PAO_OFS_CTRL        8'h00
`define PAO_OFS_STATUS      8'h04
`define PAO_OFS_IRQ_STAT    8'h08
`define PAO_OFS_IRQ_MASK    8'h0C
`define PAO_OFS_SAMPLE      8'h10
`define PAO_OFS_PERIOD      8'h14

// ==========================================================================
// field positions
// ==========================================================================
`define PAO_CTRL_SOFT_PD    0
`define PAO_ST_REF_SETTLED  0
`define PAO_ST_EQ_ENABLED   1
`define PAO_ST_CLK_DIFF     2
`define PAO_ST_GRAY         3
`define PAO_ST_POWERED_DOWN 4
`define PAO_ST_EQ_LOCKED    5
`define PAO_IRQ_OVER_RANGE  0
`define PAO_IRQ_REF_SETTLED 1
`define PAO_IRQ_WORD_READY  2
`define PAO_IRQ_W           3

// ==========================================================================
// reset values
// ==========================================================================
`define PAO_CTRL_RST        1'b0
`define PAO_IRQ_MASK_RST    3'h0
`define PAO_WORD_RST        12'h000

// ==========================================================================
// output code limits
// ==========================================================================
`define PAO_SIGN_FLIP       12'h800
`define PAO_TC_MAX          12'h7FF
`define PAO_TC_MIN          12'h800

// ==========================================================================
// timing
// ==========================================================================
`define PAO_CLK_KHZ         50000
`define PAO_WAKE_TIME_MS    10
`define PAO_WAKE_CYC        (`PAO_WAKE_TIME_MS * `PAO_CLK_KHZ)
`define PAO_PIPE_STAGES     10
`define PAO_ALIGN_HALVES    7
`define PAO_EQ_LOCK_EDGES   100

`endif

// ### rtl/pao_out_format.v
`timescale 1ns/10ps
`include "pao_defs.vh"
// ==========================================================================
// clamp and output code conversion
// ==========================================================================
module pao_out_format #(
  parameter W = 14
) (
  // raw corrected result, signed
  input  wire [W-1:0] raw,
  input  wire         gray_sel,
  // coded word
  output reg  [11:0]  code,
  output reg          over_range
);

  reg [11:0] tc;
  reg [11:0] offs;

  // upper bits not all equal means beyond full scale
  always @*
  begin
    tc   = raw[11:0];
    offs = 12'h000;
    over_range = ~((&raw[W-1:11]) | ~(|raw[W-1:11]));
    if (over_range)
      tc = raw[W-1] ? `PAO_TC_MIN : `PAO_TC_MAX;
    offs = tc ^ `PAO_SIGN_FLIP;
    if (gray_sel)
      code = offs ^ {1'b0, offs[11:1]};
    else
      code = tc;
  end

endmodule // pao_out_format

// ### rtl/pao_pipeline.v
`timescale 1ns/10ps
// ==========================================================================
// half-period pipeline: stages followed by alignment delay
// ==========================================================================
module pao_pipeline #(
  parameter W      = 14,
  parameter STAGES = 10,
  parameter ALIGN  = 7
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_b,
  // control
  input  wire         flush,
  input  wire         step,
  input  wire         load,
  // data
  input  wire [W-1:0] din,
  output wire [W-1:0] dout,
  output wire         dout_vld
);

  localparam N = STAGES + ALIGN;

  reg [W-1:0] data_r [0:N-1];
  reg         vld_r  [0:N-1];

  // every half period each entry moves one place on
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_stage
      always @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          data_r[i] <= {W{1'b0}};
          vld_r[i]  <= 1'b0;
        end
        else if (flush)
        begin
          vld_r[i]  <= 1'b0;
        end
        else if (step)
        begin
          if (i == 0)
          begin
            data_r[i] <= din;
            vld_r[i]  <= load;
          end
          else
          begin
            data_r[i] <= data_r[(i > 0) ? i - 1 : 0];
            vld_r[i]  <= vld_r[(i > 0) ? i - 1 : 0];
          end
        end
      end
    end
  endgenerate

  assign dout     = data_r[N-1];
  assign dout_vld = vld_r[N-1];

endmodule // pao_pipeline

// ### rtl/pao_top.v
`timescale 1ns/10ps
`include "pao_defs.vh"
// Operation
// - equalizer strap low disables, high enables
// - clock type strap: single-ended or differential
// - over-range flag high beyond full scale
// - twelve bit word, bit eleven most significant
// - valid strobe from clock, duty corrected
// - power-down input high enters power-down
// - reference enabled only outside power-down
// - format strap: two's complement or gray
// - result appears 8.5 clocks after sampling
// - ten stages, one step per half period
// - reference needs 10 ms settle time
// - sample taken on clock falling edge
// - data changes while strobe is low, captured rising
// - outputs high impedance during power-down
// - clamp codes, flag asserted when out of range
module pao_top #(
  parameter WAKE_CYC = `PAO_WAKE_CYC,
  parameter SAMPLE_W = 14,
  parameter PER_W    = 16
) (
  // clock and reset
  input  wire                   ref_clk,
  input  wire                   rst_b,
  // avalon-mm slave
  input  wire [`PAO_ADDR_W-1:0] avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  input  wire [3:0]             avs_byteenable,
  output reg  [31:0]            avs_readdata,
  output reg                    avs_waitrequest,
  // straps and power
  input  wire                   duty_equalizer_enable,
  input  wire                   clock_input_type,
  input  wire                   code_format_select,
  input  wire                   power_down_request,
  // sample clock pins
  input  wire                   clock_in_pos,
  input  wire                   clock_in_neg,
  // quantizer result, signed, wider than the output word
  input  wire [SAMPLE_W-1:0]    analog_sample,
  // back-end outputs
  output reg  [11:0]            sample_word,
  output reg                    sample_word_oe,
  output reg                    over_range_flag,
  output reg                    over_range_oe,
  output reg                    sample_valid_strobe,
  output reg                    sample_valid_oe,
  // analog control and interrupt
  output reg                    reference_enable,
  output reg                    irq
);

  // ========================================================================
  // declarations
  // ========================================================================
  reg                     ctrl_soft_pd_r;
  reg  [`PAO_IRQ_W-1:0]   irq_stat_r;
  reg  [`PAO_IRQ_W-1:0]   irq_stat_nxt;
  reg  [`PAO_IRQ_W-1:0]   irq_mask_r;
  reg                     eq_en_r;
  reg                     clk_diff_r;
  reg                     gray_r;
  reg                     clk_lvl_r;
  reg                     clk_lvl_nxt;
  reg  [31:0]             wake_cnt_r;
  reg                     ref_settled_r;
  reg  [PER_W-1:0]        per_cnt_r;
  reg  [PER_W-1:0]        period_r;
  reg  [PER_W-1:0]        hi_cnt_r;
  reg  [6:0]              lock_cnt_r;
  reg                     dav_nxt;
  reg  [11:0]             last_word_r;
  reg                     last_ovr_r;
  wire                    pd_act;
  wire                    fall_tick;
  wire                    rise_tick;
  wire                    half_tick;
  wire                    eq_locked;
  wire                    word_tick;
  wire                    acc;
  wire [SAMPLE_W-1:0]     pipe_out;
  wire                    pipe_vld;
  wire [11:0]             fmt_code;
  wire                    fmt_ovr;

  // ========================================================================
  // power-down and straps
  // ========================================================================
  // pin or software request both enter power-down
  // power-down entry
  assign pd_act = power_down_request | ctrl_soft_pd_r;

  // straps are live pins, sampled every cycle
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eq_en_r    <= 1'b0;
      clk_diff_r <= 1'b0;
      gray_r     <= 1'b0;
    end
    else
    begin
      eq_en_r    <= duty_equalizer_enable;
      clk_diff_r <= clock_input_type;
      gray_r     <= code_format_select;
    end
  end

  // reference follows power state
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      reference_enable <= 1'b0;
    else
      reference_enable <= ~pd_act;
  end

  // settle counter restarts at reset and at every wake
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wake_cnt_r    <= 32'h0000_0000;
      ref_settled_r <= 1'b0;
    end
    else if (pd_act)
    begin
      wake_cnt_r    <= 32'h0000_0000;
      ref_settled_r <= 1'b0;
    end
    else if (wake_cnt_r >= WAKE_CYC - 1)
      ref_settled_r <= 1'b1;
    else
      wake_cnt_r <= wake_cnt_r + 32'h0000_0001;
  end

  // ========================================================================
  // sample clock recovery
  // ========================================================================
  // a differential pair with both legs equal carries no level; hold
  always @*
  begin
    clk_lvl_nxt = clk_lvl_r;
    if (!clk_diff_r)
      clk_lvl_nxt = clock_in_pos;
    else if (clock_in_pos != clock_in_neg)
      clk_lvl_nxt = clock_in_pos;
  end

  // clock pins float in power-down, so the level is frozen there
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      clk_lvl_r <= 1'b0;
    else if (!pd_act)
      clk_lvl_r <= clk_lvl_nxt;
  end

  assign fall_tick = ~pd_act & clk_lvl_r & ~clk_lvl_nxt;
  assign rise_tick = ~pd_act & ~clk_lvl_r & clk_lvl_nxt;
  assign half_tick = fall_tick | rise_tick;

  // ========================================================================
  // conversion pipeline
  // ========================================================================
  // ten stages, half-period steps
  pao_pipeline #(
    .W      (SAMPLE_W),
    .STAGES (`PAO_PIPE_STAGES),
    .ALIGN  (`PAO_ALIGN_HALVES)
  ) u_pipe (
    .clk      (ref_clk),
    .rst_b    (rst_b),
    .flush    (pd_act),
    .step     (half_tick),
    .load     (fall_tick),
    .din      (analog_sample),
    .dout     (pipe_out),
    .dout_vld (pipe_vld)
  );

  pao_out_format #(
    .W (SAMPLE_W)
  ) u_fmt (
    .raw        (pipe_out),
    .gray_sel   (gray_r),
    .code       (fmt_code),
    .over_range (fmt_ovr)
  );

  // a word leaves only on a rising clock edge, once per period
  // one word per period
  assign word_tick = rise_tick & pipe_vld;

  // ========================================================================
  // output word and over-range flag
  // ========================================================================
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sample_word     <= `PAO_WORD_RST;
      over_range_flag <= 1'b0;
    end
    else if (word_tick)
    begin
      // bit 11 is msb, bit 0 lsb
      sample_word     <= fmt_code;
      over_range_flag <= fmt_ovr;
    end
  end

  // enables drop with power-down; the pins then float
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sample_word_oe  <= 1'b0;
      over_range_oe   <= 1'b0;
      sample_valid_oe <= 1'b0;
    end
    else
    begin
      sample_word_oe  <= ~pd_act;
      over_range_oe   <= ~pd_act;
      sample_valid_oe <= ~pd_act;
    end
  end

  // ========================================================================
  // duty-cycle equalizer
  // ========================================================================
  // period measured between falling edges, in system clocks
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      per_cnt_r <= {PER_W{1'b0}};
      period_r  <= {PER_W{1'b0}};
    end
    else if (pd_act)
      per_cnt_r <= {PER_W{1'b0}};
    else if (fall_tick)
    begin
      period_r  <= per_cnt_r + {{(PER_W-1){1'b0}}, 1'b1};
      per_cnt_r <= {PER_W{1'b0}};
    end
    else if (~&per_cnt_r)
      per_cnt_r <= per_cnt_r + {{(PER_W-1){1'b0}}, 1'b1};
  end

  // lock needs a run of falling edges; limitation: no relock on drift
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      lock_cnt_r <= 7'h00;
    else if (pd_act | ~eq_en_r)
      lock_cnt_r <= 7'h00;
    else if (fall_tick & ~eq_locked)
      lock_cnt_r <= lock_cnt_r + 7'h01;
  end

  assign eq_locked = (lock_cnt_r >= `PAO_EQ_LOCK_EDGES);

  // ========================================================================
  // valid strobe
  // ========================================================================
  // strobe falls by each rising clock edge, when the word changes; once locked, at half the measured period if that comes sooner
  always @*
  begin
    dav_nxt = sample_valid_strobe;
    if (eq_locked)
    begin
      if (rise_tick)
        dav_nxt = 1'b0;
      else if (fall_tick)
        dav_nxt = 1'b1;
      else if (hi_cnt_r == {{(PER_W-1){1'b0}}, 1'b1})
        dav_nxt = 1'b0;
    end
    // strobe falls as the word changes
    else if (!pd_act)
      dav_nxt = ~clk_lvl_nxt;
  end

  // high time is half the measured period, or less if the clock rises sooner
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sample_valid_strobe <= 1'b0;
      hi_cnt_r            <= {PER_W{1'b0}};
    end
    else
    begin
      sample_valid_strobe <= dav_nxt;
      if (fall_tick)
        hi_cnt_r <= {1'b0, period_r[PER_W-1:1]};
      else if (rise_tick)
        hi_cnt_r <= {PER_W{1'b0}};
      else if (hi_cnt_r != {PER_W{1'b0}})
        hi_cnt_r <= hi_cnt_r - {{(PER_W-1){1'b0}}, 1'b1};
    end
  end

  // ========================================================================
  // avalon slave: one wait state, then answer
  // ========================================================================
  assign acc = ~avs_waitrequest & (avs_read | avs_write);

  // readback copy of the last word leaving the pipeline
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      last_word_r <= `PAO_WORD_RST;
      last_ovr_r  <= 1'b0;
    end
    else if (word_tick)
    begin
      last_word_r <= fmt_code;
      last_ovr_r  <= fmt_ovr;
    end
  end

  // waitrequest high by default; drops for one cycle per request
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      avs_waitrequest <= 1'b1;
    else if (!avs_waitrequest)
      avs_waitrequest <= 1'b1;
    else if (avs_read | avs_write)
      avs_waitrequest <= 1'b0;
  end

  // read data are set up as waitrequest drops; unmapped reads zero
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      avs_readdata <= 32'h0000_0000;
    else if (avs_waitrequest & avs_read)
    begin
      case (avs_address)
        `PAO_OFS_CTRL:     avs_readdata <= {31'h0000_0000, ctrl_soft_pd_r};
        `PAO_OFS_STATUS:   avs_readdata <= {26'h000_0000, eq_locked, pd_act,
                                            gray_r, clk_diff_r, eq_en_r,
                                            ref_settled_r};
        `PAO_OFS_IRQ_STAT: avs_readdata <= {29'h0000_0000, irq_stat_r};
        `PAO_OFS_IRQ_MASK: avs_readdata <= {29'h0000_0000, irq_mask_r};
        `PAO_OFS_SAMPLE:   avs_readdata <= {7'h00, last_ovr_r, 12'h000,
                                            last_word_r};
        `PAO_OFS_PERIOD:   avs_readdata <= {{(32-PER_W){1'b0}}, period_r};
        default:           avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // writes take effect at the edge where waitrequest is low
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_soft_pd_r <= `PAO_CTRL_RST;
      irq_mask_r     <= `PAO_IRQ_MASK_RST;
    end
    else if (acc & avs_write & avs_byteenable[0])
    begin
      if (avs_address == `PAO_OFS_CTRL)
        ctrl_soft_pd_r <= avs_writedata[`PAO_CTRL_SOFT_PD];
      if (avs_address == `PAO_OFS_IRQ_MASK)
        irq_mask_r <= avs_writedata[`PAO_IRQ_W-1:0];
    end
  end

  // ========================================================================
  // interrupts
  // ========================================================================
  // clear only the bits the read returned, then new events; set wins
  always @*
  begin
    irq_stat_nxt = irq_stat_r;
    if (acc & avs_read & (avs_address == `PAO_OFS_IRQ_STAT))
      irq_stat_nxt = irq_stat_r & ~avs_readdata[`PAO_IRQ_W-1:0];
    if (word_tick & fmt_ovr)
      irq_stat_nxt[`PAO_IRQ_OVER_RANGE] = 1'b1;
    if (~pd_act & ~ref_settled_r & (wake_cnt_r >= WAKE_CYC - 1))
      irq_stat_nxt[`PAO_IRQ_REF_SETTLED] = 1'b1;
    if (word_tick)
      irq_stat_nxt[`PAO_IRQ_WORD_READY] = 1'b1;
  end

  // level interrupt while any unmasked status bit is set
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_stat_r <= {`PAO_IRQ_W{1'b0}};
      irq        <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      irq        <= |(irq_stat_nxt & irq_mask_r);
    end
  end

endmodule // pao_top

// ### tb/pao_backend_model.sv
`timescale 1ns/10ps
// ==========================================================================
// back-end capture logic on the far side
module pao_backend_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // lines from the converter
  input  wire logic [11:0] word,
  input  wire logic        word_oe,
  input  wire logic        flag,
  input  wire logic        stb,
  input  wire logic        stb_oe,
  // captured result
  output logic [11:0]      cap_word,
  output logic             cap_flag,
  output logic             cap_evt
);
  logic             stb_q;
  logic [11:0]      last_w;
  wire logic [11:0] w_line = word_oe ? word : ~last_w;
  wire logic        s_line = stb_oe ? stb : ~stb_q;
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stb_q   <= 1'b0;
      last_w  <= 12'h000;
      cap_evt <= 1'b0;
    end
    else
    begin
      stb_q    <= s_line;
      last_w   <= w_line;
      cap_evt  <= s_line && !stb_q && stb_oe;
      cap_word <= w_line;
      cap_flag <= flag;
    end
  end
endmodule // pao_backend_model

// ### tb/pao_top_checker.sv
`timescale 1ns/10ps
// ==========================================================================
// port checker for the converter output block
module pao_top_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // bus handshake
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // power and sample clock
  input wire logic        power_down_request,
  input wire logic        clock_input_type,
  input wire logic        clock_in_pos,
  // back-end outputs
  input wire logic [11:0] sample_word,
  input wire logic        sample_word_oe,
  input wire logic        over_range_flag,
  input wire logic        over_range_oe,
  input wire logic        sample_valid_strobe,
  input wire logic        sample_valid_oe,
  input wire logic        reference_enable
);
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // bus answers one cycle after the take, for one cycle only
  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
  property p_bus_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_bus_one: assert property (p_bus_one) else $error("bus answer too long");
  // power-down floats outputs and drops the reference
  property p_pd_float;
    power_down_request [*3] |-> !sample_word_oe && !over_range_oe && !sample_valid_oe;
  endproperty
  a_pd_float: assert property (p_pd_float) else $error("outputs driven in power-down");
  property p_pd_ref;
    power_down_request [*3] |-> !reference_enable;
  endproperty
  a_pd_ref: assert property (p_pd_ref) else $error("reference on in power-down");
  property p_oe_same;
    sample_word_oe == over_range_oe && over_range_oe == sample_valid_oe
      && sample_valid_oe == reference_enable;
  endproperty
  a_oe_same: assert property (p_oe_same) else $error("enables disagree");
  // word moves only with the strobe low, and stands at its rise
  property p_word_move;
    $changed(sample_word) && sample_word_oe && $past(sample_word_oe) |-> !sample_valid_strobe;
  endproperty
  a_word_move: assert property (p_word_move) else $error("word moved, strobe high");
  property p_rise_stable;
    $rose(sample_valid_strobe) |-> $stable(sample_word) && $stable(over_range_flag);
  endproperty
  a_rise_stable: assert property (p_rise_stable) else $error("word moved at rise");
  // clamped code whenever the flag is up
  property p_clamp;
    over_range_flag && sample_word_oe |-> sample_word inside {12'h7ff, 12'h800, 12'h000};
  endproperty
  a_clamp: assert property (p_clamp) else $error("flag without clamp code");
  // no second strobe rise within two cycles of one
  property p_gap;
    $rose(sample_valid_strobe) |=> (!$rose(sample_valid_strobe)) [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("strobe too often");
  // strobe rises shortly after each single-ended sample clock fall
  property p_strobe;
    $fell(clock_in_pos) && !clock_input_type && sample_word_oe && !power_down_request
      && !$past(power_down_request) |-> ##[1:4] $rose(sample_valid_strobe);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe missing");
endmodule // pao_top_checker

bind pao_top pao_top_checker u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .power_down_request(power_down_request),
  .clock_input_type(clock_input_type), .clock_in_pos(clock_in_pos),
  .sample_word(sample_word), .sample_word_oe(sample_word_oe),
  .over_range_flag(over_range_flag), .over_range_oe(over_range_oe),
  .sample_valid_strobe(sample_valid_strobe), .sample_valid_oe(sample_valid_oe),
  .reference_enable(reference_enable));

// ### tb/pipelined_adc_output_control_test.sv
`timescale 1ns/10ps
`include "pao_defs.vh"
// ==========================================================================
// self-checking bench for the converter output block
module pipelined_adc_output_control_test;
  localparam int WAKE = 20;
  logic        ref_clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, live = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, q, r;
  logic [3:0]  be = 4'hf;
  logic        eq_en = 1'b0, ck_type = 1'b0, gsel = 1'b0, pwr_dn = 1'b0;
  logic        cpos = 1'b0, cneg = 1'b0;
  logic [13:0] asmp = 14'h0000;
  logic [13:0] hist [256];
  logic [2:0]  ph = 3'h0;
  int          n_fall = 0, errors = 0, num_checks = 0, seed = 20002;
  wire [31:0]  rdata;
  wire [11:0]  word, cap_word;
  wire         wreq, word_oe, ovr, ovr_oe, stb, stb_oe, ref_en, irq, cap_flag, cap_evt;
  localparam logic [13:0] CRN [6] = '{14'h07ff, 14'h0800, 14'h3800, 14'h37ff, 14'h0000, 14'h3fff};
  initial forever #10 ref_clk = ~ref_clk;
  pao_top #(.WAKE_CYC(WAKE)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .duty_equalizer_enable(eq_en),
    .clock_input_type(ck_type), .code_format_select(gsel), .power_down_request(pwr_dn),
    .clock_in_pos(cpos), .clock_in_neg(cneg), .analog_sample(asmp), .sample_word(word),
    .sample_word_oe(word_oe), .over_range_flag(ovr), .over_range_oe(ovr_oe),
    .sample_valid_strobe(stb), .sample_valid_oe(stb_oe), .reference_enable(ref_en), .irq(irq));
  pao_backend_model u_be (.ref_clk(ref_clk), .rst_b(rst_b), .word(word), .word_oe(word_oe),
    .flag(ovr), .stb(stb), .stb_oe(stb_oe), .cap_word(cap_word), .cap_flag(cap_flag),
    .cap_evt(cap_evt));
  // expected code: clamp, then optional gray
  function automatic logic [12:0] exp_code(input logic [13:0] s, input logic g);
    logic        ov;
    logic [11:0] tc;
    logic [11:0] o;
    ov = !(s[13:11] == 3'h0 || s[13:11] == 3'h7);
    tc = ov ? (s[13] ? `PAO_TC_MIN : `PAO_TC_MAX) : s[11:0];
    o  = tc ^ `PAO_SIGN_FLIP;
    return {ov, g ? (o ^ (o >> 1)) : tc};
  endfunction
  task automatic results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bad(input string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e, input string m);
    num_checks++;
    if (g !== e)
      bad($sformatf("%s got %h exp %h", m, g, e));
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    num_checks++;
    if (g !== e)
      bad(m);
  endtask
  task automatic chk_word(input logic [12:0] g, input logic [12:0] e);
    num_checks++;
    if (g !== e)
      bad($sformatf("word got %h exp %h", g, e));
  endtask
  // one bus cycle, held until waitrequest is seen low
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] b);
    int n;
    n = 0;
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    be    <= b;
    rd    <= !w;
    wr    <= w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
    begin
      bad("bus hang");
      results();
    end
  endtask
  task automatic align;
    @(posedge ref_clk);
    while (ph != 3'd1)
      @(posedge ref_clk);
  endtask
  // sample clock at ref/8, new value at each rise, history at each fall
  always @(posedge ref_clk)
  begin
    ph <= ph + 3'd1;
    if (ph == 3'd0)
    begin
      r = $random(seed);
      cpos <= 1'b1;
      cneg <= 1'b0;
      asmp <= (n_fall % 5 == 2) ? CRN[(n_fall / 5) % 6] :
              (r[13] ? r[13:0] : {{2{r[11]}}, r[11:0]});
    end
    if (ph == 3'd4)
    begin
      cpos <= 1'b0;
      cneg <= ck_type;
      hist[n_fall[7:0]] <= asmp;
      n_fall <= n_fall + 1;
    end
    if (!rst_b || pwr_dn)
      n_fall <= 0;
  end
  // captured word against the sample nine falls earlier
  always @(posedge ref_clk)
    if (cap_evt && live && n_fall >= 10)
      chk_word({cap_flag, cap_word}, exp_code(hist[8'(n_fall - 10)], gsel));
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad("run timeout");
    results();
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    align();
    rst_b <= 1'b1;
    av(1'b0, `PAO_OFS_STATUS, 32'h0, 4'hf);
    chk_reg(q & 32'h3f, 32'h0, "status at reset");
    repeat (WAKE + 10) @(posedge ref_clk);
    chk_bit(irq, 1'b0, "irq masked");
    av(1'b1, `PAO_OFS_IRQ_MASK, 32'h2, 4'hf);
    repeat (2) @(posedge ref_clk);
    chk_bit(irq, 1'b1, "irq raised");
    av(1'b0, `PAO_OFS_IRQ_STAT, 32'h0, 4'hf);
    chk_reg(q & 32'h2, 32'h2, "settle event");
    repeat (2) @(posedge ref_clk);
    chk_bit(irq, 1'b0, "irq cleared");
    av(1'b1, 8'h40, 32'h7, 4'hf);
    av(1'b1, `PAO_OFS_IRQ_MASK, 32'h7, 4'he);
    av(1'b0, `PAO_OFS_IRQ_MASK, 32'h0, 4'hf);
    chk_reg(q, 32'h2, "mask kept");
    av(1'b0, 8'hfc, 32'h0, 4'hf);
    chk_reg(q, 32'h0, "unmapped read");
    av(1'b1, `PAO_OFS_CTRL, 32'h1, 4'hf);
    av(1'b0, `PAO_OFS_STATUS, 32'h0, 4'hf);
    chk_reg(q & 32'h10, 32'h10, "soft down");
    av(1'b1, `PAO_OFS_CTRL, 32'h0, 4'hf);
    live <= 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      align();
      pwr_dn <= 1'b1;
      live   <= 1'b0;
      repeat (4) @(posedge ref_clk);
      chk_bit(ref_en | word_oe | stb_oe | ovr_oe, 1'b0, "power-down");
      av(1'b0, `PAO_OFS_STATUS, 32'h0, 4'hf);
      chk_reg(q & 32'h10, 32'h10, "status down");
      gsel    <= c[0];
      ck_type <= c[1];
      eq_en   <= c[1] ^ c[0];
      align();
      pwr_dn <= 1'b0;
      av(1'b0, `PAO_OFS_STATUS, 32'h0, 4'hf);
      chk_reg(q & 32'h1f, 32'(c[0]) << 3 | 32'(c[1]) << 2 | 32'(c[1] ^ c[0]) << 1,
              "straps");
      live <= 1'b1;
      repeat (1040) @(posedge ref_clk);
      av(1'b0, `PAO_OFS_STATUS, 32'h0, 4'hf);
      chk_reg(q & 32'h21, 32'(c[1] ^ c[0]) << 5 | 32'h1, "lock and settle");
    end
    results();
  end
endmodule // pipelined_adc_output_control_test
